// ==== rtl/three_level_counter.sv ====
// Three nested signed do-while counters with an AXI4-Lite register file.
// Assumes go and en come from logic on aclk and held loop ports.
`timescale 1ns/10ps
`include "loop_counter_regs.svh"
module three_level_counter (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Loop control
  input  wire logic                          go,
  input  wire logic                          en,
  input  wire loop_counter_pkg::port_val_t [2:0] loop_start_in,
  input  wire loop_counter_pkg::port_val_t [2:0] loop_incr_in,
  input  wire loop_counter_pkg::port_val_t [2:0] loop_end_in,
  // Loop results
  output logic                               count_valid,
  output logic                               last_step_flag,
  output loop_counter_pkg::count_t           count_i,
  output loop_counter_pkg::count_t           count_j,
  output loop_counter_pkg::count_t           count_k,
  // AXI4-Lite write address
  input  wire logic [7:0]                    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // AXI4-Lite write response
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // AXI4-Lite read address
  input  wire logic [7:0]                    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  // AXI4-Lite read data
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready
);
  import loop_counter_pkg::*;

  // ==========================================================
  // Declarations
  run_state_t         state_q;
  run_state_t         state_d;
  logic               valid_q;
  logic               last_q;
  count_t             out_q [`LEVELS];
  logic               ctrl_en_q;
  logic               sw_go_q;
  word_t              cfg_q [`NUM_CFG];
  logic               aw_got_q;
  logic               w_got_q;
  logic [`ADDR_W-1:0] aw_addr_q;
  word_t              w_data_q;
  logic [3:0]         w_strb_q;
  logic               awready_q;
  logic               wready_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               arready_q;
  logic               rvalid_q;
  word_t              rdata_q;
  logic [1:0]         rresp_q;
  logic               go_any;
  logic               en_any;
  logic               take_go;
  logic               advance;
  logic               all_end;
  logic [2:0]         at_end_w;
  logic [2:0]         inner_ok;
  count_t             cnt_w [`LEVELS];
  loop_level_if       lvl_if [`LEVELS] ();

  // ==========================================================
  // Run control
  // Software go and the go pin act alike
  assign go_any  = go | sw_go_q;
  assign en_any  = en & ctrl_en_q;
  assign take_go = en_any & go_any;
  assign advance = en_any & ~go_any & (state_q == RUN_COUNT);
  assign all_end = &at_end_w;
  always_comb begin
    state_d = state_q;
    if (take_go) begin
      state_d = RUN_COUNT;
    end else if (advance && all_end) begin
      state_d = RUN_WAIT;
    end
  end

  // ==========================================================
  // Levels and operands
  assign inner_ok[2] = 1'b1;
  assign inner_ok[1] = at_end_w[2];
  assign inner_ok[0] = at_end_w[2] & at_end_w[1];
  genvar lv;
  generate
    for (lv = 0; lv < `LEVELS; lv = lv + 1) begin : g_level
      count_t st_encl;
      count_t inc_encl;
      count_t cst [`PARAMS];
      assign cst[0] = count_t'(cfg_q[lv*`PARAMS+0][`CNT_W-1:0]);
      assign cst[1] = count_t'(cfg_q[lv*`PARAMS+1][`CNT_W-1:0]);
      assign cst[2] = count_t'(cfg_q[lv*`PARAMS+2][`CNT_W-1:0]);
      // Reload sees the enclosing count it is about to take
      if (lv == 0) begin : g_outer
        assign st_encl  = cst[0];
        assign inc_encl = cst[1];
      end else begin : g_inner
        assign st_encl  = lvl_if[lv-1].count_nx;
        assign inc_encl = lvl_if[lv-1].count;
      end
      operand_select u_start (
        .sel     (cfg_q[lv*`PARAMS+0][`CFG_SRC_MSB:`CFG_SRC_LSB]),
        .const_v (cst[0]),
        .encl_v  (st_encl),
        .port_v  (loop_start_in[lv]),
        .value   (lvl_if[lv].start_v)
      );
      operand_select u_incr (
        .sel     (cfg_q[lv*`PARAMS+1][`CFG_SRC_MSB:`CFG_SRC_LSB]),
        .const_v (cst[1]),
        .encl_v  (inc_encl),
        .port_v  (loop_incr_in[lv]),
        .value   (lvl_if[lv].incr_v)
      );
      operand_select u_end (
        .sel     (cfg_q[lv*`PARAMS+2][`CFG_SRC_MSB:`CFG_SRC_LSB]),
        .const_v (cst[2]),
        .encl_v  ((lv == 0) ? cst[2] : inc_encl),
        .port_v  (loop_end_in[lv]),
        .value   (lvl_if[lv].end_v)
      );
      assign lvl_if[lv].load = take_go;
      assign lvl_if[lv].step = advance & inner_ok[lv];
      assign at_end_w[lv]    = lvl_if[lv].at_end;
      assign cnt_w[lv]       = lvl_if[lv].count;
      loop_level u_level (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lvl     (lvl_if[lv])
      );
    end
  endgenerate

  // ==========================================================
  // Run state and result flops
  // reset to waiting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= RUN_WAIT;
      valid_q <= 1'b0;
      last_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      valid_q <= advance;
      if (en_any) begin
        last_q <= advance & all_end;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `LEVELS; i++) begin
        out_q[i] <= '0;
      end
    end else if (advance) begin
      for (int i = 0; i < `LEVELS; i++) begin
        out_q[i] <= cnt_w[i];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  logic               aw_fire;
  logic               w_fire;
  logic               wr_do;
  logic               aw_got_d;
  logic               w_got_d;
  logic               bvalid_d;
  logic [`ADDR_W-1:0] wr_off;
  logic               wr_ctrl;
  logic               wr_cfg;
  logic               wr_ro;
  logic [3:0]         wr_idx;
  word_t              wr_merged;
  assign aw_fire  = awvalid & awready_q;
  assign w_fire   = wvalid & wready_q;
  // Both halves must be held before the write takes effect
  assign wr_do    = aw_got_q & w_got_q & ~bvalid_q;
  assign aw_got_d = wr_do ? 1'b0 : (aw_got_q | aw_fire);
  assign w_got_d  = wr_do ? 1'b0 : (w_got_q | w_fire);
  assign bvalid_d = wr_do | (bvalid_q & ~bready);
  assign wr_off   = aw_addr_q - `REG_CFG_BASE;
  assign wr_idx   = wr_off[5:2];
  assign wr_ctrl  = (aw_addr_q == `REG_CTRL);
  assign wr_ro    = (aw_addr_q == `REG_STATUS) |
                    (aw_addr_q == `REG_COUNT_IJ) |
                    (aw_addr_q == `REG_COUNT_K);
  assign wr_cfg   = (aw_addr_q >= `REG_CFG_BASE) &
                    (aw_addr_q <= `REG_CFG_LAST) &
                    (aw_addr_q[1:0] == 2'h0);
  // Lanes without strobe keep the stored byte
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wr_merged[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8] :
                                               cfg_q[wr_idx][b*8 +: 8];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q  <= ~w_got_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_fire) begin
        aw_addr_q <= awaddr;
      end
      if (w_fire) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_do) begin
        bresp_q <= (wr_ctrl | wr_cfg | wr_ro) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end
  // Go bit is a one-cycle pulse; it never reads back as one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_q <= 1'(`RST_CTRL >> `CTRL_EN_BIT);
      sw_go_q   <= 1'b0;
    end else begin
      sw_go_q <= wr_do & wr_ctrl & w_strb_q[0] & w_data_q[`CTRL_GO_BIT];
      if (wr_do && wr_ctrl && w_strb_q[0]) begin
        ctrl_en_q <= w_data_q[`CTRL_EN_BIT];
      end
    end
  end
  // Loop configuration words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < `NUM_CFG; c++) begin
        cfg_q[c] <= (c % `PARAMS == 0) ? `RST_START :
                    (c % `PARAMS == 1) ? `RST_INCR : `RST_END;
      end
    end else if (wr_do && wr_cfg) begin
      cfg_q[wr_idx] <= wr_merged;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  logic               ar_fire;
  logic               rvalid_d;
  logic [`ADDR_W-1:0] rd_off;
  logic               rd_cfg;
  logic               rd_hit;
  word_t              rd_word;
  word_t              status_w;
  assign ar_fire  = arvalid & arready_q;
  assign rvalid_d = ar_fire | (rvalid_q & ~rready);
  assign rd_off   = araddr - `REG_CFG_BASE;
  assign rd_cfg   = (araddr >= `REG_CFG_BASE) &
                    (araddr <= `REG_CFG_LAST) &
                    (araddr[1:0] == 2'h0);
  assign status_w = {28'h0000000, en_any, last_q, valid_q,
                     (state_q == RUN_COUNT)};
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = '0;
    case (araddr)
      `REG_CTRL:     rd_word = {30'h00000000, ctrl_en_q, 1'b0};
      `REG_STATUS:   rd_word = status_w;
      `REG_COUNT_IJ: rd_word = {out_q[1], out_q[0]};
      `REG_COUNT_K:  rd_word = {16'h0000, out_q[2]};
      default: begin
        rd_hit  = rd_cfg;
        rd_word = rd_cfg ? cfg_q[rd_off[5:2]] : '0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= `RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_fire) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Outputs
  // valid, last, counts
  assign count_valid    = valid_q;
  assign last_step_flag = last_q;
  assign count_i        = out_q[0];
  assign count_j        = out_q[1];
  assign count_k        = out_q[2];
  assign awready        = awready_q;
  assign wready         = wready_q;
  assign bvalid         = bvalid_q;
  assign bresp          = bresp_q;
  assign arready        = arready_q;
  assign rvalid         = rvalid_q;
  assign rdata          = rdata_q;
  assign rresp          = rresp_q;
endmodule : three_level_counter

// ==== rtl/loop_counter_regs.svh ====
// Offsets, field positions, widths and reset values of the loop counter.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef LOOP_COUNTER_REGS_SVH
`define LOOP_COUNTER_REGS_SVH

// ==========================================================
// Widths
`define CNT_W          16
`define PORT_W         8
`define LEVELS         3
`define PARAMS         3
`define NUM_CFG        9
`define ADDR_W         8

// ==========================================================
// Register offsets
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_COUNT_IJ   8'h08
`define REG_COUNT_K    8'h0C
`define REG_CFG_BASE   8'h10
`define REG_CFG_LAST   8'h30

// ==========================================================
// Fields
`define CTRL_GO_BIT    0
`define CTRL_EN_BIT    1
`define CFG_SRC_LSB    16
`define CFG_SRC_MSB    17
`define SRC_CONST      2'h0
`define SRC_ENCL       2'h1
`define SRC_PORT       2'h2

// ==========================================================
// Reset values and bus answers
`define RST_CTRL       32'h0000_0002
`define RST_START      32'h0000_0000
`define RST_INCR       32'h0000_0001
`define RST_END        32'h0000_0003
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ==== rtl/loop_counter_pkg.sv ====
// Types shared by the loop counter modules.
// Assumes the constants header is on the include path.
package loop_counter_pkg;
  `include "loop_counter_regs.svh"

  typedef enum logic {RUN_WAIT, RUN_COUNT}    run_state_t;
  typedef logic signed [`CNT_W-1:0]           count_t;
  typedef logic signed [`PORT_W-1:0]          port_val_t;
  typedef logic [1:0]                         src_sel_t;
  typedef logic [31:0]                        word_t;
endpackage : loop_counter_pkg

// ==== rtl/loop_level_if.sv ====
// Control and status of one counting level.
// Assumes the level and its controller share one clock.
`timescale 1ns/10ps
interface loop_level_if;
  import loop_counter_pkg::*;

  logic   load;
  logic   step;
  logic   at_end;
  count_t start_v;
  count_t incr_v;
  count_t end_v;
  count_t count;
  count_t count_nx;

  modport ctrl  (output load, step, start_v, incr_v, end_v,
                 input  count, count_nx, at_end);
  modport level (input  load, step, start_v, incr_v, end_v,
                 output count, count_nx, at_end);
endinterface : loop_level_if

// ==== rtl/operand_select.sv ====
// Picks one loop operand: constant, enclosing count or input port.
// Assumes the port value is held while counting.
`timescale 1ns/10ps
`include "loop_counter_regs.svh"
module operand_select (
  // Selection
  input  wire loop_counter_pkg::src_sel_t  sel,
  // Candidates
  input  wire loop_counter_pkg::count_t    const_v,
  input  wire loop_counter_pkg::count_t    encl_v,
  input  wire loop_counter_pkg::port_val_t port_v,
  // Result
  output loop_counter_pkg::count_t         value
);
  import loop_counter_pkg::*;

  count_t port_ext;

  assign port_ext = {{(`CNT_W-`PORT_W){port_v[`PORT_W-1]}}, port_v};

  assign value = (sel == `SRC_ENCL) ? encl_v :
                 (sel == `SRC_PORT) ? port_ext : const_v;
endmodule : operand_select

// ==== rtl/loop_level.sv ====
// One signed counting level of the nested loop.
// Assumes load and step come only while the block is enabled.
`timescale 1ns/10ps
module loop_level (
  // Clock and reset
  input  wire logic    aclk,
  input  wire logic    aresetn,
  // Level control
  loop_level_if.level  lvl
);
  import loop_counter_pkg::*;

  count_t count_q;
  count_t count_d;
  count_t stepped;

  assign lvl.at_end   = (count_q == lvl.end_v);
  // Overflow simply wraps; the end test may then never hit
  assign stepped      = count_t'(count_q + lvl.incr_v);
  assign lvl.count    = count_q;
  assign lvl.count_nx = count_d;

  always_comb begin
    if (lvl.load) begin
      count_d = lvl.start_v;
    end else if (lvl.step) begin
      count_d = lvl.at_end ? lvl.start_v : stepped;
    end else begin
      count_d = count_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : loop_level

// ==== verification/loop_ctrl_model.sv ====
// Surrounding control logic feeding the nested loop counter.
// Assumes bench requests change right after a rising aclk edge.
`timescale 1ns/10ps
module loop_ctrl_model (
  // Clock
  input  wire logic                              aclk,
  // Bench requests
  input  wire logic                              go_req,
  input  wire logic                              en_req,
  input  wire logic                              set_req,
  input  wire loop_counter_pkg::port_val_t [2:0] s_req,
  input  wire loop_counter_pkg::port_val_t [2:0] e_req,
  // Counter side
  output logic                                   go,
  output logic                                   en,
  output loop_counter_pkg::port_val_t [2:0]      loop_start_in,
  output loop_counter_pkg::port_val_t [2:0]      loop_incr_in,
  output loop_counter_pkg::port_val_t [2:0]      loop_end_in
);
  import loop_counter_pkg::*;

  assign go = go_req;
  assign en = en_req;
  assign loop_incr_in = {3{8'h01}};

  // ports held while counting
  // Only loaded on request, which comes while the counter waits
  // One process, so the ports keep a single driver
  initial begin
    loop_start_in = '0;
    loop_end_in   = '0;
    forever begin
      @(posedge aclk);
      if (set_req) begin
        loop_start_in <= s_req;
        loop_end_in   <= e_req;
      end
    end
  end
endmodule : loop_ctrl_model

// ==== verification/three_level_counter_asserts.sv ====
// Checker on the loop side ports of the nested loop counter.
// Assumes the control enable bit stays set throughout.
`timescale 1ns/10ps
module three_level_counter_asserts (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Loop control
  input wire logic                     go,
  input wire logic                     en,
  // Loop results
  input wire logic                     count_valid,
  input wire logic                     last_step_flag,
  input wire loop_counter_pkg::count_t count_i,
  input wire loop_counter_pkg::count_t count_j,
  input wire loop_counter_pkg::count_t count_k
);
  import loop_counter_pkg::*;

  // ==========================================================
  // Properties
  property p_reset;
    @(posedge aclk) !aresetn |=> !count_valid && !last_step_flag;
  endproperty
  a_reset: assert property (p_reset)
    else $error("valid or last high after reset");

  property p_en_low;
    @(posedge aclk) disable iff (!aresetn) !en |=> !count_valid;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("valid high after disabled edge");

  property p_freeze;
    @(posedge aclk) disable iff (!aresetn)
      !en |=> $stable({count_i, count_j, count_k, last_step_flag});
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while disabled");

  property p_go_gap;
    @(posedge aclk) disable iff (!aresetn) go && en |=> !count_valid;
  endproperty
  a_go_gap: assert property (p_go_gap)
    else $error("iteration emitted in load cycle");

  property p_go_start;
    @(posedge aclk) disable iff (!aresetn)
      go && en ##1 en && !go |=> count_valid;
  endproperty
  a_go_start: assert property (p_go_start)
    else $error("no iteration after start");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
      count_valid && !last_step_flag && en && !go |=> count_valid;
  endproperty
  a_step: assert property (p_step)
    else $error("iteration missing while counting");

  property p_last_end;
    @(posedge aclk) disable iff (!aresetn)
      count_valid && last_step_flag && en && !go
      |=> !count_valid && !last_step_flag;
  endproperty
  a_last_end: assert property (p_last_end)
    else $error("no return to waiting after last");

  property p_last_valid;
    @(posedge aclk) disable iff (!aresetn)
      $rose(last_step_flag) |-> count_valid;
  endproperty
  a_last_valid: assert property (p_last_valid)
    else $error("last flag without iteration");
endmodule : three_level_counter_asserts

// ==== verification/three_level_counter_bench.sv ====
// Self-checking bench for the nested loop counter.
// Assumes the design, package and header compile first.
`timescale 1ns/10ps
`include "loop_counter_regs.svh"
module three_level_counter_bench;
  import loop_counter_pkg::*;

  logic            aclk, aresetn, go, en, go_r, en_r, set_r;
  port_val_t [2:0] s_r, e_r, ls, li, le;
  logic            count_valid, last_step_flag;
  count_t          count_i, count_j, count_k;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready;
  int              failures, compares;
  logic [48:0]     q[$];
  logic [31:0]     rv[3] = '{`RST_START, `RST_INCR, `RST_END};

  loop_ctrl_model loop_ctrl_model_inst (
    .aclk(aclk), .go_req(go_r), .en_req(en_r), .set_req(set_r),
    .s_req(s_r), .e_req(e_r), .go(go), .en(en),
    .loop_start_in(ls), .loop_incr_in(li), .loop_end_in(le));

  three_level_counter three_level_counter_inst (
    .aclk(aclk), .aresetn(aresetn), .go(go), .en(en),
    .loop_start_in(ls), .loop_incr_in(li), .loop_end_in(le),
    .count_valid(count_valid), .last_step_flag(last_step_flag),
    .count_i(count_i), .count_j(count_j), .count_k(count_k),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ==========================================================
  // Compare and report
  task report_and_stop;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task cmp_w(input string n, input logic [31:0] x, y);
    compares++;
    if (x !== y) begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask : cmp_w

  task cmp_it(input string n, input logic [48:0] x, y);
    compares++;
    if (x !== y) begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask : cmp_it

  task cmp_b(input string n, input logic x, y);
    compares++;
    if (x !== y) begin
      failures++;
      $display("Error %s expected %b seen %b", n, x, y);
    end
  endtask : cmp_b

  // ==========================================================
  // Register bus
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    cmp_w("bresp", {30'h0, x}, {30'h0, bresp});
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    cmp_w("rdata", d, rdata);
    cmp_w("rresp", {30'h0, x}, {30'h0, rresp});
  endtask : rd

  // ==========================================================
  // Loop model and run
  // do-while, inclusive exact end
  task gen(input int s[3], c[3], e[3], input bit ji);
    int i, j, k;
    q.delete();
    i = s[0];
    do begin
      j = ji ? i : s[1];
      do begin
        k = s[2];
        do begin
          q.push_back({16'(i), 16'(j), 16'(k),
                       1'(i == e[0] && j == e[1] && k == e[2])});
          k += c[2];
        end while (k != e[2] + c[2]);
        j += c[1];
      end while (j != e[1] + c[1]);
      i += c[0];
    end while (i != e[0] + c[0]);
  endtask : gen

  task chk(input int x, input logic v);
    cmp_b("valid", v, count_valid);
    cmp_it("iter", q[x], {count_i, count_j, count_k, last_step_flag});
  endtask : chk

  task run(input int st, input int rs);
    int x;
    x = 0;
    @(posedge aclk) go_r <= 1'b1;
    @(posedge aclk) go_r <= 1'b0;
    @(negedge aclk) cmp_b("gap", 1'b0, count_valid);
    while (x < q.size()) begin
      if (x == st) begin
        @(posedge aclk);
        en_r <= 1'b0;
        go_r <= 1'b1;
        @(negedge aclk) chk(x, 1'b1);
        repeat (2) @(negedge aclk) chk(x, 1'b0);
        @(posedge aclk);
        en_r <= 1'b1;
        go_r <= 1'b0;
        @(negedge aclk) chk(x, 1'b0);
      end else if (x == rs) begin
        @(posedge aclk) go_r <= 1'b1;
        @(negedge aclk) chk(x, 1'b1);
        @(posedge aclk) go_r <= 1'b0;
        @(negedge aclk) cmp_b("gap", 1'b0, count_valid);
        rs = -1;
        x = -1;
      end else
        @(negedge aclk) chk(x, 1'b1);
      x++;
    end
    @(negedge aclk) cmp_b("valid", 1'b0, count_valid);
    cmp_b("last", 1'b0, last_step_flag);
  endtask : run

  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    report_and_stop;
  end

  initial begin
    {aresetn, go_r, set_r, awvalid, wvalid, bready, arvalid, rready} = '0;
    en_r = 1'b1;
    s_r = '0;
    e_r = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_CTRL, `RST_CTRL, `RESP_OKAY);
    for (int n = 0; n < 9; n++)
      rd(8'h10 + 8'(4 * n), rv[n % 3], `RESP_OKAY);
    rd(8'h40, 32'h0, `RESP_SLVERR);
    wr(8'h40, 32'h1, `RESP_SLVERR);
    wr(`REG_STATUS, 32'hF, `RESP_OKAY);
    rd(`REG_STATUS, 32'h8, `RESP_OKAY);
    wr(`REG_CTRL, `RST_CTRL, `RESP_OKAY);
    gen('{0, 0, 0}, '{1, 1, 1}, '{3, 3, 3}, 1'b0);
    run(10, -1);
    rd(`REG_COUNT_IJ, 32'h0003_0003, `RESP_OKAY);
    rd(`REG_COUNT_K, 32'h0000_0003, `RESP_OKAY);
    rd(`REG_STATUS, 32'h8, `RESP_OKAY);
    @(posedge aclk);
    en_r <= 1'b0;
    go_r <= 1'b1;
    repeat (3) @(negedge aclk) cmp_b("valid", 1'b0, count_valid);
    @(posedge aclk);
    en_r <= 1'b1;
    go_r <= 1'b0;
    // Inner start and end from ports, inner step constant -1, middle starts at outer count
    s_r[2] <= 8'h02;
    e_r[2] <= 8'hFF;
    set_r  <= 1'b1;
    @(posedge aclk) set_r <= 1'b0;
    wr(8'h18, 32'h0000_0001, `RESP_OKAY);
    wr(8'h1C, 32'h0001_0000, `RESP_OKAY);
    wr(8'h28, 32'h0002_0000, `RESP_OKAY);
    wr(8'h2C, 32'h0000_FFFF, `RESP_OKAY);
    wr(8'h30, 32'h0002_0000, `RESP_OKAY);
    rd(8'h2C, 32'h0000_FFFF, `RESP_OKAY);
    gen('{0, 0, 2}, '{1, 1, -1}, '{1, 3, -1}, 1'b1);
    run(-1, 5);
    wr(`REG_CTRL, 32'h0000_0003, `RESP_OKAY);
    rd(`REG_STATUS, 32'hB, `RESP_OKAY);
    report_and_stop;
  end
endmodule : three_level_counter_bench

bind three_level_counter three_level_counter_asserts
  three_level_counter_asserts_inst (
    .aclk(aclk), .aresetn(aresetn), .go(go), .en(en),
    .count_valid(count_valid), .last_step_flag(last_step_flag),
    .count_i(count_i), .count_j(count_j), .count_k(count_k));
